// ---- ftw_pkg.sv ----
package ftw_pkg;
    localparam logic [3:0] FTW_ADDR_TIMING   = 4'h0;
    localparam logic [3:0] FTW_ADDR_KEY      = 4'h1;
    localparam logic [3:0] FTW_ADDR_CTRL     = 4'h2;
    localparam logic [3:0] FTW_ADDR_STATUS   = 4'h3;
    localparam int         FTW_WAKE_LSB      = 0;
    localparam int         FTW_REQ_LSB       = 4;
    localparam int         FTW_APPLIED_LSB   = 8;
    localparam int         FTW_HALVE_BIT     = 0;
    localparam int         FTW_STAT_MATCH_BIT = 0;
    localparam int         FTW_STAT_WAKE_BIT = 1;
    localparam int         FTW_STAT_RD_BIT   = 2;
    localparam logic [3:0] FTW_WAKE_RESET    = 4'h4;
    localparam logic [3:0] FTW_WAKE_FIXED    = 4'hb;
    localparam logic [2:0] FTW_WAIT_MAX      = 3'h4;
    localparam logic [2:0] FTW_WAIT_RESET    = 3'h0;
    // key values are arbitrary
    localparam logic [31:0] FTW_USER_KEY     = 32'h1234_5678;
    localparam logic [31:0] FTW_VENDOR_KEY   = 32'h8765_4321;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [31:0] wdata;
    } ftw_bus_type;
endpackage

// ---- ftw_regs.sv ----
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
module ftw_regs (
    // clock, reset, enable
    input  wire logic               clock,
    input  wire logic               rst,
    input  wire logic               clk_en,
    // register port
    input  wire ftw_pkg::ftw_bus_type bus,
    output logic [31:0]             rdata,
    // flash side
    input  wire logic               flash_busy,
    input  wire logic               refclk_tick,
    input  wire logic               wake_start,
    output logic                    wake_done,
    input  wire logic               read_start,
    output logic                    read_done,
    output logic [2:0]              applied_read_wait_count
);
    import ftw_pkg::*;

    // software fields
    logic [3:0]  wakeup_time_nibble_q;
    logic [2:0]  requested_read_wait_count_q;
    logic [2:0]  applied_q;
    logic        refclk_halve_q;

    // unlock state
    logic        user_key_q;
    logic        vendor_key_q;

    // timers
    logic        half_q;
    logic [7:0]  wake_cnt_q;
    logic        wake_run_q;
    logic [2:0]  rd_cnt_q;
    logic        rd_run_q;
    logic        ref_en;

    // registered outputs, and the combinational read data rdata_d
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        wake_done_q;
    logic        read_done_q;

    function automatic logic [7:0] compose(input logic [3:0] nib);
        return {nib, FTW_WAKE_FIXED};
    endfunction

    // one strobe decode shared by every writable register
    function automatic logic wr_hit(input ftw_bus_type b,
                                    input logic [3:0] a);
        return b.wr && b.addr == a;
    endfunction

    // bit 7 and bits above 10 read as zero
    function automatic logic [31:0] timing_word(input logic [2:0] applied,
                                                input logic [2:0] req,
                                                input logic [3:0] nib);
        logic [31:0] w;
        w = 32'h0;
        w[FTW_APPLIED_LSB +: 3] = applied;
        w[FTW_REQ_LSB +: 3]     = req;
        w[FTW_WAKE_LSB +: 4]    = nib;
        return w;
    endfunction

    function automatic logic [31:0] status_word(input logic rd_run,
                                                input logic wake_run,
                                                input logic match);
        logic [31:0] w;
        w = 32'h0;
        w[FTW_STAT_RD_BIT]    = rd_run;
        w[FTW_STAT_WAKE_BIT]  = wake_run;
        w[FTW_STAT_MATCH_BIT] = match;
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // keys: any other key write drops both
    // one key at a time: a vendor write drops the user key
    // software relocks by writing any other value
    always_ff @(posedge clock) begin
        if (rst) begin
            user_key_q   <= 1'b0;
            vendor_key_q <= 1'b0;
        end else if (clk_en && wr_hit(bus, FTW_ADDR_KEY)) begin
            user_key_q   <= bus.wdata == FTW_USER_KEY;
            vendor_key_q <= bus.wdata == FTW_VENDOR_KEY;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wakeup_time_nibble_q <= FTW_WAKE_RESET;
        end else if (clk_en && wr_hit(bus, FTW_ADDR_TIMING)
                     && user_key_q) begin
            wakeup_time_nibble_q <= bus.wdata[FTW_WAKE_LSB +: 4];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            requested_read_wait_count_q <= FTW_WAIT_RESET;
        // an out-of-range request is dropped whole, never clamped
        end else if (clk_en && wr_hit(bus, FTW_ADDR_TIMING)
                     && vendor_key_q
                     && bus.wdata[FTW_REQ_LSB +: 3] <= FTW_WAIT_MAX) begin
            requested_read_wait_count_q <= bus.wdata[FTW_REQ_LSB +: 3];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            refclk_halve_q <= 1'b0;
        // halving is guarded by the user key, like the wakeup nibble
        end else if (clk_en && wr_hit(bus, FTW_ADDR_CTRL)
                     && user_key_q) begin
            refclk_halve_q <= bus.wdata[FTW_HALVE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // software polls this before touching the bus clock
    // adopt only when no flash activity, ours or outside
    always_ff @(posedge clock) begin
        if (rst) begin
            applied_q <= FTW_WAIT_RESET;
        end else if (clk_en && !flash_busy && !rd_run_q && !wake_run_q) begin
            applied_q <= requested_read_wait_count_q;
        end
    end
    assign applied_read_wait_count = applied_q;

    // halving drops every other reference tick
    // the first halved period may be one tick short after a toggle
    always_ff @(posedge clock) begin
        if (rst) begin
            half_q <= 1'b0;
        end else if (clk_en && refclk_tick) begin
            half_q <= ~half_q;
        end
    end
    assign ref_en = refclk_tick && (!refclk_halve_q || half_q);

    ////////////////////////////////////////////////////////////////////
    // wake timer counts effective reference ticks down to zero
    // the zero count still waits one tick, so count+1 periods in all
    always_ff @(posedge clock) begin
        if (rst) begin
            wake_run_q  <= 1'b0;
            wake_cnt_q  <= 8'h00;
            wake_done_q <= 1'b0;
        end else if (clk_en) begin
            wake_done_q <= 1'b0;
            if (!wake_run_q && wake_start) begin
                wake_run_q <= 1'b1;
                wake_cnt_q <= compose(wakeup_time_nibble_q);
            end else if (wake_run_q && ref_en) begin
                if (wake_cnt_q == 8'h00) begin
                    wake_run_q <= 1'b0;
                    wake_done_q <= 1'b1;
                end else begin
                    wake_cnt_q <= wake_cnt_q - 8'h01;
                end
            end
        end
    end

    assign wake_done = wake_done_q;

    ////////////////////////////////////////////////////////////////////
    // read wait states; a zero count answers in the next cycle
    // a count change mid-read waits: applied_q holds while we run
    always_ff @(posedge clock) begin
        if (rst) begin
            rd_run_q    <= 1'b0;
            rd_cnt_q    <= 3'h0;
            read_done_q <= 1'b0;
        end else if (clk_en) begin
            read_done_q <= 1'b0;
            if (!rd_run_q && read_start) begin
                if (applied_q == 3'h0) begin
                    read_done_q <= 1'b1;
                end else begin
                    rd_run_q <= 1'b1;
                    rd_cnt_q <= applied_q;
                end
            end else if (rd_run_q) begin
                if (rd_cnt_q == 3'h1) begin
                    rd_run_q    <= 1'b0;
                    read_done_q <= 1'b1;
                end
                rd_cnt_q <= rd_cnt_q - 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // idle and unmapped reads give zero
    always_comb begin
        rdata_d = 32'h0;
        if (bus.rd) begin
            case (bus.addr)
                FTW_ADDR_TIMING: rdata_d = timing_word(applied_q,
                    requested_read_wait_count_q, wakeup_time_nibble_q);
                FTW_ADDR_CTRL:   rdata_d[FTW_HALVE_BIT] = refclk_halve_q;
                FTW_ADDR_STATUS: rdata_d = status_word(rd_run_q, wake_run_q,
                    applied_q == requested_read_wait_count_q);
                default:         rdata_d = 32'h0;
            endcase
        end
    end

    // read data stand for the one cycle after the strobe only
    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_q <= 32'h0;
        end else if (clk_en) begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata     = rdata_q;
    assign read_done = read_done_q;
endmodule

// ---- ftw_flash_model.sv ----
`timescale 1ns/1ps
module ftw_flash_model #(parameter int TICK_DIV = 3) (
    // clock and busy request from the bench
    input  wire logic clock,
    input  wire logic busy_req,
    // flash side
    output logic      flash_busy,
    output logic      refclk_tick
);
    int cnt_q = 0;
    always_ff @(posedge clock) begin
        cnt_q <= (cnt_q == TICK_DIV - 1) ? 0 : cnt_q + 1;
        refclk_tick <= (cnt_q == 0);
        flash_busy <= busy_req;
    end
endmodule

// ---- ftw_regs_props.sv ----
`timescale 1ns/1ps
module ftw_regs_props (
    input wire logic                 clock,
    input wire logic                 rst,
    input wire logic                 clk_en,
    input wire ftw_pkg::ftw_bus_type bus,
    input wire logic [31:0]          rdata,
    input wire logic                 flash_busy,
    input wire logic                 refclk_tick,
    input wire logic                 wake_start,
    input wire logic                 wake_done,
    input wire logic                 read_start,
    input wire logic                 read_done,
    input wire logic [2:0]           applied_read_wait_count
);
    import ftw_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_read_no_wait: assert property (
        read_start && applied_read_wait_count == 3'h0 |=> read_done)
        else $error("read_done late");
    a_read_three_waits: assert property (
        read_start && applied_read_wait_count == 3'h3
        |=> !read_done [*3] ##1 read_done) else $error("wait count off");
    a_applied_max: assert property (
        applied_read_wait_count <= FTW_WAIT_MAX) else $error("applied high");
    a_req_max: assert property (
        bus.rd && bus.addr == FTW_ADDR_TIMING |=> rdata[6:4] <= FTW_WAIT_MAX)
        else $error("requested high");
    a_applied_hold: assert property (
        flash_busy |=> $stable(applied_read_wait_count))
        else $error("applied moved while busy");
    a_applied_read: assert property (
        bus.rd && bus.addr == FTW_ADDR_TIMING
        |=> rdata[10:8] == $past(applied_read_wait_count))
        else $error("applied field wrong");
    a_wake_quiet: assert property (
        wake_start |=> !wake_done [*8]) else $error("wake done early");
    a_wake_pulse: assert property (
        wake_done |=> !wake_done) else $error("wake done too long");
endmodule

// ---- tb_ftw_regs.sv ----
`timescale 1ns/1ps
module tb_ftw_regs;
    import ftw_pkg::*;
    logic clock = 0, rst = 1, clk_en = 1, busy_req = 0;
    logic wake_start = 0, read_start = 0;
    ftw_bus_type bus = '0;
    logic [31:0] rdata;
    logic flash_busy, refclk_tick, wake_done, read_done;
    logic [2:0] applied_read_wait_count;
    int fail_count = 0, total_checks = 0, n;
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
    fail_count++; $display("mismatch %0t got %h", $time, a); end end
    initial begin
        forever #10 clock = ~clock;
    end
    ftw_flash_model i_flash (.clock, .busy_req, .flash_busy, .refclk_tick);
    ftw_regs i_dut (.clock, .rst, .clk_en, .bus, .rdata, .flash_busy,
        .refclk_tick, .wake_start, .wake_done, .read_start, .read_done,
        .applied_read_wait_count);
    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge clock);
        bus <= '{1'b1, 1'b0, a, d};
        @(posedge clock);
        bus <= '0;
    endtask
    task automatic rd(logic [3:0] a, logic [31:0] e);
        @(posedge clock);
        bus <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge clock);
        bus <= '0;
        // data stand until the next edge; sample there, before they drop
        @(posedge clock);
        `CHK(rdata, e)
    endtask
    // count cycles from the start pulse to the done pulse
    task automatic pulse(bit w, int lo, int hi);
        @(posedge clock);
        if (w) wake_start <= 1; else read_start <= 1;
        @(posedge clock);
        {wake_start, read_start} <= 2'b00;
        #1;
        for (n = 0; (w ? wake_done : read_done) !== 1'b1 && n < 200; n++)
            @(posedge clock) #1;
        `CHK(n >= lo && n <= hi, 1'b1)
    endtask
    task automatic t_reset;
        rd(FTW_ADDR_TIMING, 32'h4);
        pulse(0, 0, 0);
    endtask
    task automatic t_lock;
        wr(FTW_ADDR_TIMING, 32'h7);
        rd(FTW_ADDR_TIMING, 32'h4);
        wr(FTW_ADDR_KEY, FTW_USER_KEY);
        wr(FTW_ADDR_TIMING, 32'h37);
        rd(FTW_ADDR_TIMING, 32'h7);
    endtask
    // the vendor key drops the user key, so the nibble stays 7
    task automatic t_wait;
        wr(FTW_ADDR_KEY, FTW_VENDOR_KEY);
        wr(FTW_ADDR_TIMING, 32'h50);
        rd(FTW_ADDR_TIMING, 32'h7);
        // busy stands for reads only, never a program or erase
        busy_req <= 1;
        wr(FTW_ADDR_TIMING, 32'h30);
        repeat (4) @(posedge clock);
        rd(FTW_ADDR_TIMING, 32'h37);
        rd(FTW_ADDR_STATUS, 32'h0);
        `CHK(applied_read_wait_count, 3'h0)
        busy_req <= 0;
        repeat (4) @(posedge clock);
        rd(FTW_ADDR_TIMING, 32'h337);
        rd(FTW_ADDR_STATUS, 32'h1);
        `CHK(applied_read_wait_count, 3'h3)
        pulse(0, 3, 3);
    endtask
    // tick every third cycle: 12 ticks for nibble 0
    task automatic t_wake;
        wr(FTW_ADDR_KEY, FTW_USER_KEY);
        wr(FTW_ADDR_TIMING, 32'h0);
        rd(FTW_ADDR_TIMING, 32'h330);
        pulse(1, 33, 39);
        wr(FTW_ADDR_CTRL, 32'h1);
        rd(FTW_ADDR_CTRL, 32'h1);
        pulse(1, 66, 78);
        // a write while the enable is low must leave the nibble alone
        @(posedge clock);
        clk_en <= 0;
        wr(FTW_ADDR_TIMING, 32'h5);
        clk_en <= 1;
        rd(FTW_ADDR_TIMING, 32'h330);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #200000 fail_count++;
        summarize;
    end
    initial begin
        repeat (12) @(posedge clock);
        rst <= 0;
        t_reset;
        t_lock;
        t_wait;
        t_wake;
        summarize;
    end
endmodule
bind ftw_regs ftw_regs_props i_props (.clock, .rst, .clk_en, .bus, .rdata,
    .flash_busy, .refclk_tick, .wake_start, .wake_done, .read_start,
    .read_done, .applied_read_wait_count);
